// file: verilog/uefa_pkg.sv
package uefa_pkg;

    localparam int unsigned NUM_SLOTS     = 16;
    localparam int unsigned SLOT_W        = 4;
    localparam int unsigned SIZE_W        = 11;
    localparam int unsigned ADDR_W        = 15;
    localparam int unsigned WB_AW         = 8;

    localparam logic [ADDR_W-1:0] STORAGE_BYTES = 15'h099e;
    localparam logic [SIZE_W-1:0] CTRL_BYTES    = 11'h040;

    localparam logic [SLOT_W-1:0] SLOT_CTRL_OUT  = 4'h0;
    localparam logic [SLOT_W-1:0] SLOT_CTRL_IN   = 4'h1;
    localparam logic [SLOT_W-1:0] SLOT_FIRST_DMA = 4'h2;
    localparam logic [SLOT_W-1:0] SLOT_LAST      = 4'hf;

    localparam logic [WB_AW-1:0] OFS_ECR_BASE   = 8'h00;
    localparam logic [WB_AW-1:0] OFS_ECR_LAST   = 8'h3c;
    localparam logic [WB_AW-1:0] OFS_DMA_CFG    = 8'h40;
    localparam logic [WB_AW-1:0] OFS_ALLOC_STAT = 8'h44;
    localparam logic [WB_AW-1:0] OFS_REGION_BASE = 8'h80;
    localparam logic [WB_AW-1:0] OFS_REGION_LAST = 8'hbc;

    localparam int unsigned ECR_EN_BIT   = 0;
    localparam int unsigned ECR_DIR_BIT  = 1;
    localparam int unsigned ECR_ISO_BIT  = 2;
    localparam int unsigned ECR_DBL_BIT  = 3;
    localparam int unsigned ECR_SIZE_LSB = 4;
    localparam int unsigned ECR_W        = 8;

    localparam int unsigned DMA_IDX_LSB = 0;
    localparam int unsigned DMA_EN_BIT  = 4;
    localparam int unsigned DMA_CFG_W   = 5;

    localparam int unsigned STAT_TOTAL_LSB = 0;
    localparam int unsigned STAT_BUSY_BIT  = 16;
    localparam int unsigned STAT_OVF_BIT   = 17;
    localparam int unsigned STAT_ERR_BIT   = 18;
    localparam int unsigned REG_SIZE_LSB   = 16;
    localparam int unsigned REG_DIR_BIT    = 28;
    localparam int unsigned REG_EN_BIT     = 29;

    localparam logic [ECR_W-1:0]     ECR_RESET     = 8'h00;
    localparam logic [ECR_W-1:0]     CTRL_OUT_ECR  = 8'h31;
    localparam logic [ECR_W-1:0]     CTRL_IN_ECR   = 8'h33;
    localparam logic [DMA_CFG_W-1:0] DMA_CFG_RESET = 5'h00;

    typedef enum logic [0:0] {
        ALLOC_IDLE = 1'b0,
        ALLOC_WALK = 1'b1
    } uefa_alloc_state_t;

endpackage

// file: verilog/uefa_size_decode.sv
`timescale 1ns/1ps
module uefa_size_decode (
    input  wire logic [3:0]                  i_code,
    input  wire logic                        i_iso,
    output logic      [uefa_pkg::SIZE_W-1:0] o_bytes,
    output logic                             o_reserved
);
    import uefa_pkg::*;

    always_comb begin
        o_reserved = 1'b0;
        o_bytes    = 11'h000;
        if (i_iso) begin
            case (i_code)
                4'h0: o_bytes = 11'h010;
                4'h1: o_bytes = 11'h020;
                4'h2: o_bytes = 11'h030;
                4'h3: o_bytes = 11'h040;
                4'h4: o_bytes = 11'h060;
                4'h5: o_bytes = 11'h080;
                4'h6: o_bytes = 11'h0a0;
                4'h7: o_bytes = 11'h0c0;
                4'h8: o_bytes = 11'h100;
                4'h9: o_bytes = 11'h140;
                4'ha: o_bytes = 11'h180;
                4'hb: o_bytes = 11'h200;
                4'hc: o_bytes = 11'h280;
                4'hd: o_bytes = 11'h300;
                4'he: o_bytes = 11'h380;
                default: o_bytes = 11'h3ff;
            endcase
        end else begin
            case (i_code)
                4'h0: o_bytes = 11'h008;
                4'h1: o_bytes = 11'h010;
                4'h2: o_bytes = 11'h020;
                4'h3: o_bytes = 11'h040;
                default: begin
                    // A reserved code gets no storage so it cannot overlap its neighbours.
                    o_bytes    = 11'h000;
                    o_reserved = 1'b1;
                end
            endcase
        end
    end

endmodule

// file: verilog/uefa_top.sv
`timescale 1ns/1ps
module uefa_top (
    input  wire logic                             i_clk,
    input  wire logic                             i_rst_n,
    input  wire logic                             i_usb_bus_rst,
    input  wire logic [6:0]                       i_dev_addr,
    input  wire logic                             i_wb_cyc,
    input  wire logic                             i_wb_stb,
    input  wire logic                             i_wb_we,
    input  wire logic [uefa_pkg::WB_AW-1:0]       i_wb_adr,
    input  wire logic [3:0]                       i_wb_sel,
    input  wire logic [31:0]                      i_wb_dat,
    output logic      [31:0]                      o_wb_dat,
    output logic                                  o_wb_ack,
    output logic                                  o_dma_valid,
    output logic                                  o_dma_dir_in,
    output logic      [uefa_pkg::ADDR_W-1:0]      o_dma_base,
    output logic      [uefa_pkg::SIZE_W-1:0]      o_dma_max_pkt,
    output logic      [11:0]                      o_dma_ep_key,
    output logic                                  o_alloc_busy,
    output logic                                  o_alloc_ovf,
    output logic                                  o_cfg_err
);
    import uefa_pkg::*;

    logic [ECR_W-1:0]     ecr_ff       [NUM_SLOTS];
    logic [ADDR_W-1:0]    region_base_ff [NUM_SLOTS];
    logic [SIZE_W-1:0]    logical_ff   [NUM_SLOTS];
    logic [DMA_CFG_W-1:0] dma_cfg_ff;
    uefa_alloc_state_t    state_ff;
    logic [SLOT_W-1:0]    walk_idx_ff;
    logic [ADDR_W-1:0]    acc_ff;
    logic [ADDR_W-1:0]    total_ff;
    logic                 err_acc_ff;
    logic                 cfg_err_ff;
    logic                 ack_ff;
    logic [31:0]          rdat_ff;

    logic                 bus_req;
    logic                 wr_stb;
    logic                 ecr_wr;
    logic [SLOT_W-1:0]    wr_slot;
    logic [ECR_W-1:0]     cur_ecr;
    logic [SIZE_W-1:0]    dec_bytes;
    logic                 dec_reserved;
    logic [SIZE_W-1:0]    cur_logical;
    logic [ADDR_W-1:0]    cur_phys;
    logic [ADDR_W-1:0]    nxt_acc;
    logic [SLOT_W-1:0]    dma_idx;

    function automatic logic in_range(input logic [WB_AW-1:0] a,
                                      input logic [WB_AW-1:0] lo,
                                      input logic [WB_AW-1:0] hi);
        in_range = (a >= lo) && (a <= hi) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic is_ctrl(input logic [SLOT_W-1:0] s);
        is_ctrl = (s == SLOT_CTRL_OUT) || (s == SLOT_CTRL_IN);
    endfunction

    assign bus_req = i_wb_cyc && i_wb_stb && !ack_ff;
    assign wr_stb  = bus_req && i_wb_we;
    assign wr_slot = i_wb_adr[SLOT_W+1:2];
    assign ecr_wr  = wr_stb && i_wb_sel[0] && in_range(i_wb_adr, OFS_ECR_BASE, OFS_ECR_LAST);
    assign dma_idx = dma_cfg_ff[DMA_IDX_LSB +: SLOT_W];
    assign cur_ecr = ecr_ff[walk_idx_ff];

    uefa_size_decode u_size_decode (
        .i_code     (cur_ecr[ECR_SIZE_LSB +: 4]),
        .i_iso      (cur_ecr[ECR_ISO_BIT]),
        .o_bytes    (dec_bytes),
        .o_reserved (dec_reserved)
    );

    always_comb begin
        cur_logical = 11'h000;
        cur_phys    = 15'h0000;
        if (is_ctrl(walk_idx_ff)) begin
            cur_logical = CTRL_BYTES;
            cur_phys    = {4'h0, CTRL_BYTES};
        end else if (cur_ecr[ECR_EN_BIT]) begin
            cur_logical = dec_bytes;
            if (cur_ecr[ECR_DBL_BIT]) begin
                cur_phys = {3'h0, dec_bytes, 1'b0};
            end else begin
                cur_phys = {4'h0, dec_bytes};
            end
        end
        nxt_acc = acc_ff + cur_phys;
    end

    // Endpoint configuration. Control slots are constants and ignore writes.
    generate
        for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_ecr
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    if (g == 0) begin
                        ecr_ff[g] <= CTRL_OUT_ECR;
                    end else if (g == 1) begin
                        ecr_ff[g] <= CTRL_IN_ECR;
                    end else begin
                        ecr_ff[g] <= ECR_RESET;
                    end
                end else if (g >= 2) begin
                    if (i_usb_bus_rst) begin
                        ecr_ff[g] <= ECR_RESET;
                    end else if (ecr_wr && (wr_slot == g[SLOT_W-1:0])) begin
                        ecr_ff[g] <= i_wb_dat[ECR_W-1:0];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dma_cfg_ff <= DMA_CFG_RESET;
        end else if (i_usb_bus_rst) begin
            dma_cfg_ff <= DMA_CFG_RESET;
        end else if (wr_stb && i_wb_sel[0] && (i_wb_adr == OFS_DMA_CFG)) begin
            dma_cfg_ff <= i_wb_dat[DMA_CFG_W-1:0];
        end
    end

    // Allocation walk: one slot per cycle, restarted by any endpoint configuration write or USB bus reset.
    // A restart mid-walk is safe because every region is rewritten from slot 0.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_ff    <= ALLOC_WALK;
            walk_idx_ff <= SLOT_CTRL_OUT;
            acc_ff      <= 15'h0000;
            err_acc_ff  <= 1'b0;
        end else if (ecr_wr || i_usb_bus_rst) begin
            state_ff    <= ALLOC_WALK;
            walk_idx_ff <= SLOT_CTRL_OUT;
            acc_ff      <= 15'h0000;
            err_acc_ff  <= 1'b0;
        end else begin
            case (state_ff)
                ALLOC_WALK: begin
                    acc_ff      <= nxt_acc;
                    err_acc_ff  <= err_acc_ff || (cur_ecr[ECR_EN_BIT] && dec_reserved && !is_ctrl(walk_idx_ff));
                    walk_idx_ff <= walk_idx_ff + 4'h1;
                    if (walk_idx_ff == SLOT_LAST) begin
                        state_ff <= ALLOC_IDLE;
                    end
                end
                default: begin
                    state_ff <= ALLOC_IDLE;
                end
            endcase
        end
    end

    generate
        for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_region
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    region_base_ff[g] <= 15'h0000;
                    logical_ff[g]     <= 11'h000;
                end else if ((state_ff == ALLOC_WALK) && (walk_idx_ff == g[SLOT_W-1:0])) begin
                    region_base_ff[g] <= acc_ff;
                    logical_ff[g]     <= cur_logical;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            total_ff   <= 15'h0000;
            cfg_err_ff <= 1'b0;
        end else if ((state_ff == ALLOC_WALK) && (walk_idx_ff == SLOT_LAST)) begin
            total_ff   <= nxt_acc;
            cfg_err_ff <= err_acc_ff || (cur_ecr[ECR_EN_BIT] && dec_reserved);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_alloc_busy <= 1'b1;
            o_alloc_ovf  <= 1'b0;
            o_cfg_err    <= 1'b0;
        end else begin
            o_alloc_busy <= (state_ff == ALLOC_WALK) || ecr_wr || i_usb_bus_rst;
            o_alloc_ovf  <= total_ff > STORAGE_BYTES;
            o_cfg_err    <= cfg_err_ff;
        end
    end

    // DMA routing. The control pair is never offered, whatever the index says.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_dma_valid   <= 1'b0;
            o_dma_dir_in  <= 1'b0;
            o_dma_base    <= 15'h0000;
            o_dma_max_pkt <= 11'h000;
            o_dma_ep_key  <= 12'h000;
        end else begin
            o_dma_valid   <= dma_cfg_ff[DMA_EN_BIT] && (dma_idx >= SLOT_FIRST_DMA)
                             && ecr_ff[dma_idx][ECR_EN_BIT] && (state_ff == ALLOC_IDLE);
            o_dma_dir_in  <= ecr_ff[dma_idx][ECR_DIR_BIT];
            o_dma_base    <= region_base_ff[dma_idx];
            o_dma_max_pkt <= logical_ff[dma_idx];
            o_dma_ep_key  <= {i_dev_addr, dma_idx - 4'h1, ecr_ff[dma_idx][ECR_DIR_BIT]};
        end
    end

    // Wishbone classic slave: ack one cycle after the strobe, for one cycle.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= bus_req;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdat_ff <= 32'h0000_0000;
        end else if (bus_req && !i_wb_we) begin
            rdat_ff <= 32'h0000_0000;
            if (in_range(i_wb_adr, OFS_ECR_BASE, OFS_ECR_LAST)) begin
                rdat_ff[ECR_W-1:0] <= ecr_ff[wr_slot];
            end else if (i_wb_adr == OFS_DMA_CFG) begin
                rdat_ff[DMA_CFG_W-1:0] <= dma_cfg_ff;
            end else if (i_wb_adr == OFS_ALLOC_STAT) begin
                rdat_ff[STAT_TOTAL_LSB +: ADDR_W] <= total_ff;
                rdat_ff[STAT_BUSY_BIT]            <= o_alloc_busy;
                rdat_ff[STAT_OVF_BIT]             <= o_alloc_ovf;
                rdat_ff[STAT_ERR_BIT]             <= o_cfg_err;
            end else if (in_range(i_wb_adr, OFS_REGION_BASE, OFS_REGION_LAST)) begin
                rdat_ff[ADDR_W-1:0]                <= region_base_ff[wr_slot];
                rdat_ff[REG_SIZE_LSB +: SIZE_W]    <= logical_ff[wr_slot];
                rdat_ff[REG_DIR_BIT]               <= ecr_ff[wr_slot][ECR_DIR_BIT];
                rdat_ff[REG_EN_BIT]                <= ecr_ff[wr_slot][ECR_EN_BIT];
            end
        end
    end

    assign o_wb_ack = ack_ff;
    assign o_wb_dat = rdat_ff;

endmodule

// file: verification/uefa_assertions.sv
`timescale 1ns/1ps
module uefa_chk (
    input  wire logic                       i_clk,
    input  wire logic                       i_rst_n,
    input  wire logic                       i_usb_bus_rst,
    input  wire logic [6:0]                 i_dev_addr,
    input  wire logic                       i_wb_cyc,
    input  wire logic                       i_wb_stb,
    input  wire logic                       i_wb_we,
    input  wire logic [uefa_pkg::WB_AW-1:0] i_wb_adr,
    input  wire logic [3:0]                 i_wb_sel,
    input  wire logic [31:0]                o_wb_dat,
    input  wire logic                       o_wb_ack,
    input  wire logic                       o_dma_valid,
    input  wire logic                       o_dma_dir_in,
    input  wire logic [uefa_pkg::ADDR_W-1:0] o_dma_base,
    input  wire logic [11:0]                o_dma_ep_key,
    input  wire logic                       o_alloc_busy
);
    import uefa_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    logic       take;
    logic       ep_wr;
    logic [7:0] busy_cnt_ff;
    assign take = i_wb_cyc && i_wb_stb && !o_wb_ack;
    // Control slot writes are dropped, so only slots 2 and up must restart the walk.
    assign ep_wr = take && i_wb_we && i_wb_sel[0] && i_wb_adr >= 8'h08 && i_wb_adr <= OFS_ECR_LAST
                   && i_wb_adr[1:0] == 2'h0;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            busy_cnt_ff <= 8'h00;
        end else begin
            busy_cnt_ff <= o_alloc_busy ? busy_cnt_ff + 8'h01 : 8'h00;
        end
    end
    a_ack_single: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack longer than one cycle");
    a_ack_answer: assert property (take |=> o_wb_ack) else $error("request not answered");
    a_ack_no_req: assert property (!(i_wb_cyc && i_wb_stb) |=> !o_wb_ack) else $error("ack without request");
    a_unmapped_zero: assert property (take && !i_wb_we && (i_wb_adr == 8'h48 || i_wb_adr[1:0] != 2'h0)
        |=> o_wb_dat == 32'h0) else $error("unmapped read not zero");
    a_ctrl_fixed: assert property (take && !i_wb_we && i_wb_adr == OFS_ECR_BASE
        |=> o_wb_dat == {24'h0, CTRL_OUT_ECR}) else $error("control slot changed");
    a_walk_start: assert property (ep_wr |=> ##[0:1] o_alloc_busy) else $error("walk not restarted");
    a_busy_bound: assert property (busy_cnt_ff < 8'h78) else $error("allocation walk too long");
    a_dma_no_ctrl: assert property (o_dma_valid |-> o_dma_base >= 15'h0080) else $error("DMA on control");
    a_key_dir: assert property (o_dma_valid |-> o_dma_ep_key[0] == o_dma_dir_in)
        else $error("key direction wrong");
    a_key_addr: assert property (o_dma_valid && i_dev_addr == $past(i_dev_addr, 3)
        |-> o_dma_ep_key[11:5] == i_dev_addr) else $error("key address wrong");
    a_bus_rst_drop: assert property (i_usb_bus_rst |-> ##[1:4] !o_dma_valid) else $error("DMA kept");
    c_ep_write: cover property (ep_wr);
    c_dma_on: cover property (o_dma_valid);
    c_bus_rst: cover property (i_usb_bus_rst ##1 !i_usb_bus_rst);
endmodule
bind uefa_top uefa_chk u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_usb_bus_rst(i_usb_bus_rst),
    .i_dev_addr(i_dev_addr), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
    .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .o_dma_valid(o_dma_valid), .o_dma_dir_in(o_dma_dir_in), .o_dma_base(o_dma_base),
    .o_dma_ep_key(o_dma_ep_key), .o_alloc_busy(o_alloc_busy));

// file: verification/uefa_fw_model.sv
`timescale 1ns/1ps
module uefa_fw_model (
    input  wire logic                       i_clk,
    input  wire logic                       i_ack,
    input  wire logic [31:0]                i_rdat,
    output logic                            o_cyc,
    output logic                            o_stb,
    output logic                            o_we,
    output logic      [uefa_pkg::WB_AW-1:0] o_adr,
    output logic      [3:0]                 o_sel,
    output logic      [31:0]                o_dat
);
    import uefa_pkg::*;
    initial begin
        o_cyc = 1'b0;
        o_stb = 1'b0;
        o_we = 1'b0;
        o_adr = 8'h00;
        o_sel = 4'hf;
        o_dat = 32'h0;
    end
    task automatic xfer(input logic we, input logic [WB_AW-1:0] adr, input logic [31:0] wd, output logic [31:0] rd);
        o_cyc <= 1'b1;
        o_stb <= 1'b1;
        o_we <= we;
        o_adr <= adr;
        o_dat <= wd;
        do @(posedge i_clk); while (i_ack !== 1'b1);
        rd = i_rdat;
        o_cyc <= 1'b0;
        o_stb <= 1'b0;
        // A released data line must not keep looking like valid write data.
        o_dat <= ~wd;
        @(posedge i_clk);
    endtask
    // No FIFO holds data in this bench, so reconfiguring is always safe here.
    // The bench only trusts the result once the walk has settled, as after enumeration.
    task automatic set_interface(input logic [7:0] endpoint_config_reg [16]);
        logic [31:0] d;
        for (int s = 0; s < 16; s++) xfer(1'b1, OFS_ECR_BASE + 8'(4 * s), {24'h0, endpoint_config_reg[s]}, d);
    endtask
endmodule

// file: verification/usb_endpoint_fifo_allocator_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin err_total++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, (e), (a)); end end
module usb_endpoint_fifo_allocator_tb_top;
    import uefa_pkg::*;
    typedef struct packed { logic [7:0] endpoint_config_reg; logic [SIZE_W-1:0] size; } uefa_row_t;
    localparam uefa_row_t ROWS [28] = '{
        '{8'h0d, 11'h010}, '{8'h17, 11'h020}, '{8'h25, 11'h030}, '{8'h35, 11'h040}, '{8'h45, 11'h060},
        '{8'h55, 11'h080}, '{8'h65, 11'h0a0}, '{8'h75, 11'h0c0}, '{8'h85, 11'h100}, '{8'h95, 11'h140},
        '{8'ha5, 11'h180}, '{8'hb5, 11'h200}, '{8'hc5, 11'h280}, '{8'hd5, 11'h300},
        '{8'he5, 11'h380}, '{8'hf7, 11'h3ff}, '{8'h01, 11'h008}, '{8'h1b, 11'h010}, '{8'h21, 11'h020},
        '{8'h39, 11'h040}, '{8'h41, 11'h000}, '{8'hf4, 11'h000}, '{8'h00, 11'h000}, '{8'h00, 11'h000},
        '{8'h00, 11'h000}, '{8'h00, 11'h000}, '{8'h00, 11'h000}, '{8'h00, 11'h000}};
    logic              clk, rst_n, bus_rst, cyc, stb, we, ack, dvalid, ddir, busy, ovf, err;
    logic [6:0]        dev_addr;
    logic [WB_AW-1:0]  adr;
    logic [3:0]        sel;
    logic [31:0]       wdat, rdat, d;
    logic [ADDR_W-1:0] dbase, sum;
    logic [ADDR_W-1:0] exp_base [16];
    logic [SIZE_W-1:0] dmax;
    logic [11:0]       dkey;
    logic [7:0]        cfg [16];
    uefa_row_t         r;
    int                err_total = 0;
    int                total_checks = 0;
    uefa_top dut (.i_clk(clk), .i_rst_n(rst_n), .i_usb_bus_rst(bus_rst), .i_dev_addr(dev_addr),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .o_wb_dat(rdat), .o_wb_ack(ack), .o_dma_valid(dvalid), .o_dma_dir_in(ddir), .o_dma_base(dbase),
        .o_dma_max_pkt(dmax), .o_dma_ep_key(dkey), .o_alloc_busy(busy), .o_alloc_ovf(ovf), .o_cfg_err(err));
    uefa_fw_model fw (.i_clk(clk), .i_ack(ack), .i_rdat(rdat), .o_cyc(cyc), .o_stb(stb), .o_we(we),
        .o_adr(adr), .o_sel(sel), .o_dat(wdat));
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [WB_AW-1:0] a, input logic [31:0] v);
        fw.xfer(1'b1, a, v, d);
    endtask
    task automatic chk_rd(input string nm, input logic [WB_AW-1:0] a, input logic [31:0] e);
        fw.xfer(1'b0, a, 32'h0, d);
        `CHK(nm, e, d)
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        @(posedge clk);
        while (busy !== 1'b0 && n < 300) begin
            @(posedge clk);
            n++;
        end
        `CHK("busy", 1'b0, busy)
        repeat (4) @(posedge clk);
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #100000;
        err_total++;
        finish_test();
    end
    initial begin
        rst_n = 1'b0;
        bus_rst = 1'b0;
        dev_addr = 7'h2a;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk_rd("ecr0", OFS_ECR_BASE, {24'h0, CTRL_OUT_ECR});
        for (int s = 2; s < 16; s++) chk_rd("ecr", OFS_ECR_BASE + 8'(4 * s), 32'h0);
        chk_rd("dma cfg", OFS_DMA_CFG, 32'h0);
        wr(OFS_ECR_BASE, 32'hff);
        chk_rd("ecr0 locked", OFS_ECR_BASE, {24'h0, CTRL_OUT_ECR});
        chk_rd("unmapped", 8'h48, 32'h0);
        chk_rd("unaligned", 8'h01, 32'h0);
        for (int p = 0; p < 2; p++) begin
            cfg[0] = 8'h00;
            cfg[1] = 8'h00;
            for (int s = 2; s < 16; s++) cfg[s] = ROWS[p * 14 + s - 2].endpoint_config_reg;
            fw.set_interface(cfg);
            wait_idle();
            chk_rd("ctrl in", OFS_REGION_BASE + 8'h04, {2'h0, 2'b11, 1'b0, CTRL_BYTES, 16'h0040});
            sum = 15'(2 * CTRL_BYTES);
            for (int s = 2; s < 16; s++) begin
                r = ROWS[p * 14 + s - 2];
                exp_base[s] = sum;
                fw.xfer(1'b0, OFS_REGION_BASE + 8'(4 * s), 32'h0, d);
                `CHK("region", {5'h0, r.size, 1'b0, sum}, d & 32'h07ff7fff)
                sum = sum + (15'(r.size) << r.endpoint_config_reg[3]);
            end
            chk_rd("status", OFS_ALLOC_STAT, {13'h0, p == 1, p == 0, 2'h0, sum});
            `CHK("ovf", p == 0, ovf)
            `CHK("err", p == 1, err)
        end
        wr(OFS_DMA_CFG, 32'h11);
        repeat (4) @(posedge clk);
        `CHK("dma ctrl", 1'b0, dvalid)
        wr(OFS_DMA_CFG, 32'h03);
        repeat (4) @(posedge clk);
        `CHK("dma off", 1'b0, dvalid)
        wr(OFS_DMA_CFG, 32'h13);
        repeat (4) @(posedge clk);
        `CHK("dma on", 1'b1, dvalid)
        `CHK("dma base", exp_base[3], dbase)
        `CHK("dma max", 11'h3ff, dmax)
        `CHK("dma dir", 1'b1, ddir)
        `CHK("dma key", {7'h2a, 4'h2, 1'b1}, dkey)
        bus_rst <= 1'b1;
        @(posedge clk);
        bus_rst <= 1'b0;
        wait_idle();
        `CHK("dma bus reset", 1'b0, dvalid)
        chk_rd("ecr3", OFS_ECR_BASE + 8'h0c, 32'h0);
        chk_rd("ecr1", OFS_ECR_BASE + 8'h04, {24'h0, CTRL_IN_ECR});
        chk_rd("dma cfg", OFS_DMA_CFG, 32'h0);
        finish_test();
    end
endmodule
